/* hdl/rsc_pkg.sv */
// Purpose: Shared constants and types of the reset source controller
// Assumes: 32-bit classic Wishbone register access, byte address = 4 * index
// Notes:   Registers are 8 bits wide and sit in the low byte lane
package rsc_pkg;

	// ------------------------------------------------------------
	// Register indices and bus geometry
	// ------------------------------------------------------------
	localparam int          ADDR_W          = 16;
	localparam int          DATA_W          = 32;
	localparam logic [11:0] IDX_CAUSE_FLAGS = 12'hfcc;
	localparam logic [11:0] IDX_CONFIG      = 12'hfde;
	localparam logic [11:0] IDX_COMMIT_KEY  = 12'hfdf;
	localparam logic [11:0] IDX_IRQ_STATUS  = 12'hfe0;
	localparam logic [11:0] IDX_IRQ_MASK    = 12'hfe1;

	// ------------------------------------------------------------
	// Commit key codes
	// ------------------------------------------------------------
	localparam logic [7:0]  KEY_PIN_DISABLE = 8'hb2;
	localparam logic [7:0]  KEY_VECT_AREA   = 8'hd4;
	localparam logic [7:0]  KEY_FLAG_CLEAR  = 8'h71;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int          BIT_PIN_DIS     = 0;
	localparam int          BIT_AREA        = 1;
	localparam int          BIT_VECTOR      = 2;
	localparam int          CFG_W           = 3;
	localparam int          BIT_WDOG        = 0;
	localparam int          BIT_CLK_FAULT   = 1;
	localparam int          BIT_VDET1       = 2;
	localparam int          BIT_VDET2       = 3;
	localparam int          BIT_TRIM        = 4;
	localparam int          BIT_TRIM_STATE  = 5;
	localparam int          BIT_FLASH       = 6;
	localparam int          BIT_FLAG_CLEAR  = 7;
	localparam int          CAUSE_W         = 7;
	localparam int          IRQ_W           = 3;
	localparam int          IRQ_INTERNAL    = 0;
	localparam int          IRQ_PIN         = 1;
	localparam int          IRQ_WARM_DONE   = 2;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0]  RST_BYTE        = 8'h00;
	localparam logic [31:0] RST_WORD        = 32'h0000_0000;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int          CLK_HZ          = 10_000_000;
	localparam int          MACHINE_CLKS    = 4;
	localparam int          SWITCH_GUARD_MC = 2;
	localparam int          WARMUP_CYCLES   = 256;

	typedef enum logic [1:0] {
		WS_HOLD,
		WS_WARM,
		WS_RUN
	} rsc_warm_state_type;

endpackage : rsc_pkg

/* hdl/rsc_sync.sv */
// Purpose: Two-stage synchroniser for pin level inputs
// Assumes: Inputs are asynchronous levels, no pulses shorter than two clocks
// Notes:   Only the second stage may be read by other logic
module rsc_sync #(
	parameter int          WIDTH = 1,
	parameter logic [31:0] INIT  = 32'h0000_0000
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Data
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_reg <= INIT[WIDTH-1:0];
			dout     <= INIT[WIDTH-1:0];
		end
		else
		begin
			meta_reg <= din;
			dout     <= meta_reg;
		end
	end

endmodule : rsc_sync

/* hdl/rsc_top.sv */
// Purpose: Reset source controller with committed pin disable and cause flags
// Assumes: RST_N is the power-on reset; fault sources come from logic on CLK
// Notes:   Registers are reached over classic Wishbone, one answer per request
// Operation
// R1 - System reset comes from pin, power-on, two voltage detectors, watchdog, clock, trim, flash.
// R2 - Committed pin-disable 0 lets the pin reset; 1 makes the pin ignored.
// R3 - Written pin-disable takes effect only when key 0xB2 is written.
// R4 - Only power-on clears committed pin-disable; every reset clears written config.
// R5 - Key 0xD4 commits config bits 2 and 1, 0x71 commits flag clear, others ignored.
// R6 - Software treats the key register as write-only, no read-modify-write.
// R7 - Software writes 0xB2 in normal mode with gear divider select 00.
// R8 - Status at key address shows committed pin-disable bit 0, others bits 2 and 1.
// R9 - Config and committed status bits 7 to 3 read as zero.
// R10 - Cause flags: watchdog 0, clock 1, voltage 1 2, voltage 2 3, trim 4, flash 6.
// R11 - Cause bit 5 reads one while abnormal trimming data is detected.
// R12 - Cause bits clear only by power-on, pin reset or committed flag clear.
// R13 - Clear bit 7 then key 0x71 clears all flags and the clear bit.
// R14 - Cause bit 7 always reads as zero.
// R15 - Software writes 0x71 in normal mode with gear divider select 00.
// R16 - Oscillator off within 2 machine cycles of clock switch raises clock reset.
// R17 - Warm-up counts after any reset release and restarts on a new reset.
// R18 - System reset while any source is active; pin counts only when enabled.
//
// The Wishbone register port was chosen for this implementation.
module rsc_top #(
	parameter int WARMUP_CYCLES = rsc_pkg::WARMUP_CYCLES,
	parameter int MACHINE_CLKS  = rsc_pkg::MACHINE_CLKS
) (
	// Clock and power-on reset
	input  wire logic                       CLK,
	input  wire logic                       RST_N,
	// Wishbone slave
	input  wire logic                       WB_CYC_I,
	input  wire logic                       WB_STB_I,
	input  wire logic                       WB_WE_I,
	input  wire logic [rsc_pkg::ADDR_W-1:0] WB_ADR_I,
	input  wire logic [3:0]                 WB_SEL_I,
	input  wire logic [rsc_pkg::DATA_W-1:0] WB_DAT_I,
	output logic      [rsc_pkg::DATA_W-1:0] WB_DAT_O,
	output logic                            WB_ACK_O,
	// External reset pin
	input  wire logic                       EXT_RESET_PIN_N,
	// Internal reset sources and abnormal trim status
	input  wire logic                       VDET1_RESET,
	input  wire logic                       VDET2_RESET,
	input  wire logic                       WATCHDOG_RESET,
	input  wire logic                       TRIM_RESET,
	input  wire logic                       FLASH_STANDBY_RESET,
	input  wire logic                       TRIM_ABNORMAL_STATE,
	// Clock generator control watch
	input  wire logic                       MAIN_CLOCK_SOURCE_SELECT,
	input  wire logic                       HIGH_OSC_ENABLE,
	// Reset outputs
	output logic                            SYS_RESET_N,
	output logic                            WARMUP_BUSY,
	output logic                            PIN_DISABLE_COMMITTED,
	output logic                            VECTOR_SELECT_COMMITTED,
	output logic                            AREA_SELECT_COMMITTED,
	output logic                            IRQ
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic idx_hit(input logic [rsc_pkg::ADDR_W-1:0] adr, input logic [11:0] idx);
		idx_hit = (adr[1:0] == 2'b00) && (adr[rsc_pkg::ADDR_W-1:2] == {2'b00, idx});
	endfunction : idx_hit
	localparam int WARM_W = $clog2(WARMUP_CYCLES + 1);
	localparam int MC_W   = $clog2(MACHINE_CLKS + 1);

	// ------------------------------------------------------------
	// Pin synchroniser
	// ------------------------------------------------------------
	logic pin_n_sync;
	rsc_sync #(.WIDTH(1), .INIT(32'h0000_0001)) i_rsc_sync (
		.clk   (CLK),
		.rst_n (RST_N),
		.din   (EXT_RESET_PIN_N),
		.dout  (pin_n_sync)
	);

	// ------------------------------------------------------------
	// Clock switch guard
	// ------------------------------------------------------------
	logic            clk_sel_prev_reg;
	logic            osc_en_prev_reg;
	logic [MC_W-1:0] mc_div_reg;
	logic            mc_tick;
	logic [1:0]      guard_cnt_reg;
	logic            clk_fault_reg;
	assign mc_tick = (mc_div_reg == MC_W'(MACHINE_CLKS - 1));
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			mc_div_reg <= '0;
		else
			mc_div_reg <= mc_tick ? '0 : mc_div_reg + MC_W'(1);
	end
	// Window restarts on every source switch; it ends at the second tick of the free-running machine-cycle divider
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			clk_sel_prev_reg <= 1'b0;
			osc_en_prev_reg  <= 1'b0;
			guard_cnt_reg    <= 2'b00;
			clk_fault_reg    <= 1'b0;
		end
		else
		begin
			clk_sel_prev_reg <= MAIN_CLOCK_SOURCE_SELECT;
			osc_en_prev_reg  <= HIGH_OSC_ENABLE;
			if (MAIN_CLOCK_SOURCE_SELECT != clk_sel_prev_reg)
				guard_cnt_reg <= 2'(rsc_pkg::SWITCH_GUARD_MC);
			else if (mc_tick && guard_cnt_reg != 2'b00)
				guard_cnt_reg <= guard_cnt_reg - 2'b01;
			clk_fault_reg <= (guard_cnt_reg != 2'b00) && osc_en_prev_reg && !HIGH_OSC_ENABLE; // R16
		end
	end

	// ------------------------------------------------------------
	// Reset combination
	// ------------------------------------------------------------
	logic       pin_dis_reg;
	logic       vect_reg;
	logic       area_reg;
	logic       pin_active;
	logic       internal_active;
	logic       any_active;
	logic [6:0] cause_set;
	assign pin_active      = !pin_n_sync && !pin_dis_reg; // R2 R18
	assign internal_active = VDET1_RESET | VDET2_RESET | WATCHDOG_RESET | clk_fault_reg
		| TRIM_RESET | FLASH_STANDBY_RESET;
	assign any_active      = pin_active | internal_active; // R1 R18
	assign cause_set[rsc_pkg::BIT_WDOG]       = WATCHDOG_RESET; // R10
	assign cause_set[rsc_pkg::BIT_CLK_FAULT]  = clk_fault_reg; // R10
	assign cause_set[rsc_pkg::BIT_VDET1]      = VDET1_RESET; // R10
	assign cause_set[rsc_pkg::BIT_VDET2]      = VDET2_RESET; // R10
	assign cause_set[rsc_pkg::BIT_TRIM]       = TRIM_RESET; // R10
	assign cause_set[rsc_pkg::BIT_TRIM_STATE] = TRIM_ABNORMAL_STATE; // R11
	assign cause_set[rsc_pkg::BIT_FLASH]      = FLASH_STANDBY_RESET; // R10

	// ------------------------------------------------------------
	// Warm-up sequencing
	// ------------------------------------------------------------
	rsc_pkg::rsc_warm_state_type state_reg;
	logic [WARM_W-1:0]           warm_cnt_reg;
	logic                        warm_done;
	assign warm_done = (state_reg == rsc_pkg::WS_WARM) && (warm_cnt_reg == WARM_W'(WARMUP_CYCLES - 1));
	// Any new reset throws the counter back, also in the middle of warm-up
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			state_reg    <= rsc_pkg::WS_HOLD;
			warm_cnt_reg <= '0;
		end
		else if (any_active)
		begin
			state_reg    <= rsc_pkg::WS_HOLD; // R17
			warm_cnt_reg <= '0;
		end
		else
		begin
			case (state_reg)
				rsc_pkg::WS_HOLD:
					state_reg <= rsc_pkg::WS_WARM; // R17
				rsc_pkg::WS_WARM:
				begin
					if (warm_done)
						state_reg <= rsc_pkg::WS_RUN;
					else
						warm_cnt_reg <= warm_cnt_reg + WARM_W'(1); // R17
				end
				rsc_pkg::WS_RUN:
					state_reg <= rsc_pkg::WS_RUN;
				default:
					state_reg <= rsc_pkg::WS_HOLD;
			endcase
		end
	end
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			SYS_RESET_N <= 1'b0;
			WARMUP_BUSY <= 1'b1;
		end
		else
		begin
			SYS_RESET_N <= !any_active; // R18
			WARMUP_BUSY <= any_active || (state_reg != rsc_pkg::WS_RUN && !warm_done);
		end
	end

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------
	logic req;
	logic wr_fire;
	logic lane0;
	logic hit_cause;
	logic hit_cfg;
	logic hit_key;
	logic hit_ists;
	logic hit_imsk;
	assign req       = WB_CYC_I && WB_STB_I;
	assign wr_fire   = req && WB_ACK_O && WB_WE_I;
	assign lane0     = WB_SEL_I[0];
	assign hit_cause = idx_hit(WB_ADR_I, rsc_pkg::IDX_CAUSE_FLAGS);
	assign hit_cfg   = idx_hit(WB_ADR_I, rsc_pkg::IDX_CONFIG);
	assign hit_key   = idx_hit(WB_ADR_I, rsc_pkg::IDX_COMMIT_KEY);
	assign hit_ists  = idx_hit(WB_ADR_I, rsc_pkg::IDX_IRQ_STATUS);
	assign hit_imsk  = idx_hit(WB_ADR_I, rsc_pkg::IDX_IRQ_MASK);
	// One wait state, ack for one cycle; unmapped addresses answer with zero
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			WB_ACK_O <= 1'b0;
		else
			WB_ACK_O <= req && !WB_ACK_O;
	end

	// ------------------------------------------------------------
	// Written configuration and commit keys
	// ------------------------------------------------------------
	logic [rsc_pkg::CFG_W-1:0] cfg_reg;
	logic                      fclr_reg;
	logic                      key_wr;
	logic [7:0]                key_val;
	logic                      flag_clear_fire;
	assign key_wr          = wr_fire && hit_key && lane0;
	assign key_val         = WB_DAT_I[7:0];
	assign flag_clear_fire = key_wr && key_val == rsc_pkg::KEY_FLAG_CLEAR && fclr_reg; // R5 R13
	// Written values are lost on every reset source, committed ones are not
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			cfg_reg  <= rsc_pkg::RST_BYTE[rsc_pkg::CFG_W-1:0];
			fclr_reg <= 1'b0;
		end
		else if (any_active)
		begin
			cfg_reg  <= '0; // R4
			fclr_reg <= 1'b0; // R4
		end
		else
		begin
			if (wr_fire && hit_cfg && lane0)
				cfg_reg <= WB_DAT_I[rsc_pkg::CFG_W-1:0];
			if (flag_clear_fire)
				fclr_reg <= 1'b0; // R13
			else if (wr_fire && hit_cause && lane0)
				fclr_reg <= WB_DAT_I[rsc_pkg::BIT_FLAG_CLEAR];
		end
	end
	// Only the power-on reset reaches the committed settings
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			pin_dis_reg <= 1'b0; // R4
			vect_reg    <= 1'b0;
			area_reg    <= 1'b0;
		end
		else if (key_wr)
		begin
			if (key_val == rsc_pkg::KEY_PIN_DISABLE)
				pin_dis_reg <= cfg_reg[rsc_pkg::BIT_PIN_DIS]; // R3
			if (key_val == rsc_pkg::KEY_VECT_AREA)
			begin
				vect_reg <= cfg_reg[rsc_pkg::BIT_VECTOR]; // R5
				area_reg <= cfg_reg[rsc_pkg::BIT_AREA]; // R5
			end
		end
	end
	assign PIN_DISABLE_COMMITTED   = pin_dis_reg;
	assign VECTOR_SELECT_COMMITTED = vect_reg;
	assign AREA_SELECT_COMMITTED   = area_reg;

	// ------------------------------------------------------------
	// Cause flags
	// ------------------------------------------------------------
	logic [rsc_pkg::CAUSE_W-1:0] cause_reg;
	logic [rsc_pkg::CAUSE_W-1:0] cause_next;
	// A cause arriving with the clear is kept: set wins over clear
	assign cause_next = ((flag_clear_fire || pin_active) ? '0 : cause_reg) | cause_set; // R12 R13
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			cause_reg <= rsc_pkg::RST_BYTE[rsc_pkg::CAUSE_W-1:0];
		else
			cause_reg <= cause_next; // R12
	end

	// ------------------------------------------------------------
	// Interrupt status and mask
	// ------------------------------------------------------------
	logic [rsc_pkg::IRQ_W-1:0] ists_reg;
	logic [rsc_pkg::IRQ_W-1:0] imsk_reg;
	logic [rsc_pkg::IRQ_W-1:0] irq_event;
	logic                      pin_active_prev_reg;
	logic                      int_active_prev_reg;
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			{pin_active_prev_reg, int_active_prev_reg} <= 2'b00;
		else
			{pin_active_prev_reg, int_active_prev_reg} <= {pin_active, internal_active};
	end
	assign irq_event[rsc_pkg::IRQ_INTERNAL]  = internal_active && !int_active_prev_reg;
	assign irq_event[rsc_pkg::IRQ_PIN]       = pin_active && !pin_active_prev_reg;
	assign irq_event[rsc_pkg::IRQ_WARM_DONE] = warm_done && !any_active;
	// Write one to clear; a new event in the same cycle keeps its bit
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			ists_reg <= '0;
		else if (wr_fire && hit_ists && lane0)
			ists_reg <= (ists_reg & ~WB_DAT_I[rsc_pkg::IRQ_W-1:0]) | irq_event;
		else
			ists_reg <= ists_reg | irq_event;
	end
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			imsk_reg <= '0;
		else if (wr_fire && hit_imsk && lane0)
			imsk_reg <= WB_DAT_I[rsc_pkg::IRQ_W-1:0];
	end
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			IRQ <= 1'b0;
		else
			IRQ <= |((ists_reg | irq_event) & imsk_reg);
	end

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	logic [7:0] rd_byte;
	always_comb
	begin
		rd_byte = rsc_pkg::RST_BYTE;
		if (hit_cause)
			rd_byte = {1'b0, cause_reg}; // R14
		else if (hit_cfg)
			rd_byte = {5'b00000, cfg_reg}; // R9
		else if (hit_key)
			rd_byte = {5'b00000, vect_reg, area_reg, pin_dis_reg}; // R8 R9
		else if (hit_ists)
			rd_byte = {5'b00000, ists_reg};
		else if (hit_imsk)
			rd_byte = {5'b00000, imsk_reg};
	end
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			WB_DAT_O <= rsc_pkg::RST_WORD;
		else if (req && !WB_ACK_O && !WB_WE_I)
			WB_DAT_O <= {24'h00_0000, rd_byte};
	end

endmodule : rsc_top

/* verif/rsc_monitor.sv */
// Purpose: Port-level checks of the reset source controller
// Assumes: Classic Wishbone, byte address is four times the register index
// Notes:   Bound to every rsc_top instance
module rsc_monitor #(
	parameter int WARMUP_CYCLES = 8,
	parameter int MACHINE_CLKS  = 4
) (
	// Clock and reset
	input wire logic                       CLK,
	input wire logic                       RST_N,
	// Bus
	input wire logic                       WB_CYC_I,
	input wire logic                       WB_STB_I,
	input wire logic                       WB_WE_I,
	input wire logic [rsc_pkg::ADDR_W-1:0] WB_ADR_I,
	input wire logic [3:0]                 WB_SEL_I,
	input wire logic [rsc_pkg::DATA_W-1:0] WB_DAT_I,
	input wire logic [rsc_pkg::DATA_W-1:0] WB_DAT_O,
	input wire logic                       WB_ACK_O,
	// Sources
	input wire logic                       EXT_RESET_PIN_N,
	input wire logic                       VDET1_RESET,
	input wire logic                       VDET2_RESET,
	input wire logic                       WATCHDOG_RESET,
	input wire logic                       TRIM_RESET,
	input wire logic                       FLASH_STANDBY_RESET,
	input wire logic                       MAIN_CLOCK_SOURCE_SELECT,
	input wire logic                       HIGH_OSC_ENABLE,
	// Outputs
	input wire logic                       SYS_RESET_N,
	input wire logic                       WARMUP_BUSY,
	input wire logic                       PIN_DISABLE_COMMITTED,
	input wire logic                       VECTOR_SELECT_COMMITTED,
	input wire logic                       AREA_SELECT_COMMITTED
);
	// ------------------------------------------------------------
	// Key write decode
	// ------------------------------------------------------------
	logic key_wr;
	logic key_pin;
	logic key_vec;
	logic any_src;

	assign key_wr  = WB_ACK_O && WB_CYC_I && WB_STB_I && WB_WE_I && WB_SEL_I[0]
		&& (WB_ADR_I == {2'h0, rsc_pkg::IDX_COMMIT_KEY, 2'h0});
	assign key_pin = key_wr && (WB_DAT_I[7:0] == rsc_pkg::KEY_PIN_DISABLE);
	assign key_vec = key_wr && (WB_DAT_I[7:0] == rsc_pkg::KEY_VECT_AREA);
	assign any_src = VDET1_RESET || VDET2_RESET || WATCHDOG_RESET || TRIM_RESET || FLASH_STANDBY_RESET;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);

	a_ack_single_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack held longer than one cycle");
	a_ack_next_cycle: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
		else $error("request not answered in the next cycle");
	a_read_upper_zero: assert property (WB_ACK_O && !WB_WE_I |-> WB_DAT_O[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	a_source_sys_reset: assert property (any_src |=> !SYS_RESET_N)
		else $error("internal source did not reset the system");
	a_pin_sys_reset: assert property ((!EXT_RESET_PIN_N && !PIN_DISABLE_COMMITTED) [*4] |-> !SYS_RESET_N)
		else $error("enabled pin did not reset the system");
	a_pin_commit_key: assert property ($changed(PIN_DISABLE_COMMITTED) |-> $past(key_pin) || $past(key_pin, 2))
		else $error("pin disable changed without its key");
	a_vect_commit_key: assert property ($changed(VECTOR_SELECT_COMMITTED) || $changed(AREA_SELECT_COMMITTED)
		|-> $past(key_vec) || $past(key_vec, 2))
		else $error("vector or area changed without its key");
	a_busy_in_reset: assert property (!SYS_RESET_N |-> ##[0:1] WARMUP_BUSY)
		else $error("warm-up busy low during reset");
	a_warm_hold_time: assert property ($rose(SYS_RESET_N) |-> WARMUP_BUSY [*8])
		else $error("warm-up ended too early");
	a_clock_fault_reset: assert property ($fell(HIGH_OSC_ENABLE)
		&& ($past(MAIN_CLOCK_SOURCE_SELECT) != $past(MAIN_CLOCK_SOURCE_SELECT, 2)) |-> ##[1:4] !SYS_RESET_N)
		else $error("oscillator stop after switch gave no reset");
endmodule : rsc_monitor

bind rsc_top rsc_monitor #(.WARMUP_CYCLES(WARMUP_CYCLES), .MACHINE_CLKS(MACHINE_CLKS)) i_rsc_monitor (.CLK, .RST_N,
	.WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .EXT_RESET_PIN_N,
	.VDET1_RESET, .VDET2_RESET, .WATCHDOG_RESET, .TRIM_RESET, .FLASH_STANDBY_RESET, .MAIN_CLOCK_SOURCE_SELECT,
	.HIGH_OSC_ENABLE, .SYS_RESET_N, .WARMUP_BUSY, .PIN_DISABLE_COMMITTED, .VECTOR_SELECT_COMMITTED,
	.AREA_SELECT_COMMITTED);

/* verif/test_rsc_top.sv */
// Purpose: Self-checking bench of the reset source controller
// Assumes: Warm-up shortened to 8 cycles
// Notes:   All expectations come from the register layout and key codes
module test_rsc_top;
	timeunit 1ns;
	timeprecision 1ns;

	// ------------------------------------------------------------
	// Stimulus and design
	// ------------------------------------------------------------
	localparam logic [15:0] A_CAUSE = {2'h0, rsc_pkg::IDX_CAUSE_FLAGS, 2'h0};
	localparam logic [15:0] A_CFG   = {2'h0, rsc_pkg::IDX_CONFIG, 2'h0};
	localparam logic [15:0] A_KEY   = {2'h0, rsc_pkg::IDX_COMMIT_KEY, 2'h0};
	localparam logic [15:0] A_IST   = {2'h0, rsc_pkg::IDX_IRQ_STATUS, 2'h0};
	localparam logic [15:0] A_IMSK  = {2'h0, rsc_pkg::IDX_IRQ_MASK, 2'h0};

	logic        clk, rst_n, cyc, stb, we, pin_n, clk_sel, osc_en, trim_bad;
	logic        ack, sys_n, busy, dis_c, vec_c, area_c, irq;
	logic [3:0]  sel;
	logic [4:0]  src;
	logic [15:0] adr;
	logic [31:0] dat_i, dat_o, q;
	logic [7:0]  d, k, cause;
	integer      seed;
	int          n_fail, cmp_count, i;

	rsc_top #(.WARMUP_CYCLES(8), .MACHINE_CLKS(4)) i_rsc_top (.CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc),
		.WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o),
		.WB_ACK_O(ack), .EXT_RESET_PIN_N(pin_n), .VDET1_RESET(src[1]), .VDET2_RESET(src[2]),
		.WATCHDOG_RESET(src[0]), .TRIM_RESET(src[3]), .FLASH_STANDBY_RESET(src[4]),
		.TRIM_ABNORMAL_STATE(trim_bad), .MAIN_CLOCK_SOURCE_SELECT(clk_sel), .HIGH_OSC_ENABLE(osc_en),
		.SYS_RESET_N(sys_n), .WARMUP_BUSY(busy), .PIN_DISABLE_COMMITTED(dis_c),
		.VECTOR_SELECT_COMMITTED(vec_c), .AREA_SELECT_COMMITTED(area_c), .IRQ(irq));

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// ------------------------------------------------------------
	// Bus and check tasks
	// ------------------------------------------------------------
	task automatic end_of_test;
		$display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_of_test

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Holds the request until ack is sampled, then releases it for one idle cycle
	task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] v);
		int n;
		@(posedge clk);
		cyc   <= 1'b1;
		stb   <= 1'b1;
		we    <= w;
		adr   <= a;
		dat_i <= {24'h0, v};
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1 && n < 40);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		chk("ack", 32'h1, {31'h0, ack});
	endtask : wb

	task automatic rd(input logic [15:0] a, input logic [7:0] e, input string nm);
		wb(1'b0, a, 8'h00);
		chk(nm, {24'h0, e}, q);
	endtask : rd

	task automatic settle;
		int n;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while ((sys_n !== 1'b1 || busy !== 1'b0) && n < 200);
		chk("settled", 32'h1, {31'h0, sys_n & ~busy});
	endtask : settle

	// Events 0 to 4 are the reset inputs, 5 a clock fault, 6 bad trim data
	task automatic hit(input int e);
		@(posedge clk);
		if (e < 5)
			src <= 5'h01 << e;
		else if (e == 6)
			trim_bad <= 1'b1;
		else
			clk_sel <= ~clk_sel;
		@(posedge clk);
		osc_en <= (e != 5);
		@(posedge clk);
		src      <= 5'h00;
		osc_en   <= 1'b1;
		trim_bad <= 1'b0;
		repeat (3) @(posedge clk);
		settle;
	endtask : hit

	function automatic logic [7:0] flag_of(input int e);
		int pos [7] = '{0, 2, 3, 4, 6, 1, 5};
		return 8'h01 << pos[e];
	endfunction : flag_of

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (20000) @(posedge clk);
		n_fail++;
		end_of_test;
	end

	initial
	begin
		{rst_n, cyc, stb, we, trim_bad, clk_sel} = 6'h00;
		{pin_n, osc_en} = 2'h3;
		src = 5'h00;
		sel = 4'hf;
		adr = 16'h0000;
		dat_i = 32'h0;
		seed = 32'hda2ee8f0;
		n_fail = 0;
		cmp_count = 0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		settle;
		rd(A_CAUSE, 8'h00, "cause");
		rd(A_KEY, 8'h00, "committed");
		rd(16'h0100, 8'h00, "unmapped");
		d = 8'($random(seed)) | 8'h01;
		wb(1'b1, A_CFG, d);
		rd(A_CFG, {5'h0, d[2:0]}, "config");
		for (i = 0; i < 4; i++)
		begin
			k = 8'($random(seed));
			if (k inside {rsc_pkg::KEY_PIN_DISABLE, rsc_pkg::KEY_VECT_AREA, rsc_pkg::KEY_FLAG_CLEAR})
				k = k ^ 8'h01;
			wb(1'b1, A_KEY, k);
		end
		rd(A_KEY, 8'h00, "committed");
		wb(1'b1, A_KEY, rsc_pkg::KEY_PIN_DISABLE);
		rd(A_KEY, 8'h01, "committed");
		wb(1'b1, A_KEY, rsc_pkg::KEY_VECT_AREA);
		rd(A_KEY, {5'h0, d[2:1], 1'b1}, "committed");
		chk("committed pins", {29'h0, d[2:1], 1'b1}, {29'h0, vec_c, area_c, dis_c});
		cause = 8'h00;
		for (i = 0; i < 7; i++)
		begin
			hit(i);
			cause = cause | flag_of(i);
			rd(A_CAUSE, cause, "cause");
		end
		rd(A_CFG, 8'h00, "config");
		rd(A_KEY, {5'h0, d[2:1], 1'b1}, "committed");
		pin_n <= 1'b0;
		for (i = 0; i < 10; i++)
		begin
			@(posedge clk);
			chk("reset out", 32'h1, {31'h0, sys_n});
		end
		pin_n <= 1'b1;
		rd(A_CAUSE, cause, "cause");
		wb(1'b1, A_IST, 8'h07);
		hit(0);
		chk("irq masked", 32'h0, {31'h0, irq});
		wb(1'b1, A_IMSK, 8'h01);
		repeat (2) @(posedge clk);
		chk("irq", 32'h1, {31'h0, irq});
		wb(1'b1, A_IST, 8'h01);
		repeat (2) @(posedge clk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		wb(1'b1, A_KEY, rsc_pkg::KEY_FLAG_CLEAR);
		rd(A_CAUSE, cause, "cause");
		wb(1'b1, A_CAUSE, 8'h80);
		rd(A_CAUSE, cause, "cause");
		wb(1'b1, A_KEY, rsc_pkg::KEY_FLAG_CLEAR);
		rd(A_CAUSE, 8'h00, "cause");
		hit(0);
		wb(1'b1, A_KEY, rsc_pkg::KEY_FLAG_CLEAR);
		rd(A_CAUSE, 8'h01, "cause");
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		settle;
		rd(A_KEY, 8'h00, "committed");
		rd(A_CAUSE, 8'h00, "cause");
		hit(0);
		wb(1'b1, A_CFG, 8'h01);
		pin_n <= 1'b0;
		repeat (4) @(posedge clk);
		chk("pin reset", 32'h0, {31'h0, sys_n});
		pin_n <= 1'b1;
		repeat (3) @(posedge clk);
		settle;
		rd(A_CAUSE, 8'h00, "cause");
		rd(A_CFG, 8'h00, "config");
		end_of_test;
	end
endmodule : test_rsc_top
